// ---- design/sram_host.sv ----
// Contract
// - write lasts while selected and strobe low, ends at earliest release
// - write strobe held low at least 35 ns
// - chip selected at least 35 ns before write ends
// - read data valid 45 ns after access start; sample no earlier
module sram_host #(
	parameter int WRITE_CYC = sram_port_pkg::WRITE_PULSE_CYC,
	parameter int READ_CYC = sram_port_pkg::ACCESS_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// user request and response
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [sram_port_pkg::ADDR_W-1:0] req_addr,
	input wire logic [sram_port_pkg::DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lane_en,
	output logic req_ready,
	output logic rsp_valid,
	output logic [sram_port_pkg::DATA_W-1:0] rsp_rdata,
	// memory pins
	output logic [sram_port_pkg::ADDR_W-1:0] address_lines,
	output logic select_low_active_n,
	output logic select_high_active,
	output logic write_strobe_n,
	output logic output_gate_n,
	output logic low_lane_select_n,
	output logic high_lane_select_n,
	input wire logic [sram_port_pkg::DATA_W-1:0] data_pins_i,
	output logic [sram_port_pkg::DATA_W-1:0] data_pins_o,
	output logic data_pins_oe
);
	// ************************************************************
	// control
	// ************************************************************
	sram_port_pkg::state_t state_q, state_d;
	logic [sram_port_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [sram_port_pkg::CNT_W-1:0] wr_last, rd_last;
	logic start, cnt_end;

	assign wr_last = sram_port_pkg::CNT_W'(WRITE_CYC - 1);
	assign rd_last = sram_port_pkg::CNT_W'(READ_CYC - 1);
	assign start = (state_q == sram_port_pkg::ST_IDLE) && req_valid;
	assign cnt_end = (state_q == sram_port_pkg::ST_WRITE) ? (cnt_q == wr_last)
		: (cnt_q == rd_last);

	// next state
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			sram_port_pkg::ST_IDLE: begin
				cnt_d = '0;
				if (req_valid) begin
					state_d = req_write ? sram_port_pkg::ST_WRITE : sram_port_pkg::ST_READ;
				end
			end
			sram_port_pkg::ST_READ, sram_port_pkg::ST_WRITE: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_end) begin
					state_d = sram_port_pkg::ST_DONE;
				end
			end
			sram_port_pkg::ST_DONE: state_d = sram_port_pkg::ST_IDLE;
			default: state_d = sram_port_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= sram_port_pkg::ST_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ************************************************************
	// pin drive
	// ************************************************************
	logic in_write, in_read, busy_d;
	assign in_write = (state_d == sram_port_pkg::ST_WRITE);
	assign in_read = (state_d == sram_port_pkg::ST_READ);
	assign busy_d = in_write || in_read;

	// select and strobe rise together; address and data held all access
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			select_low_active_n <= 1'b1;
			select_high_active <= 1'b0;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
			data_pins_oe <= 1'b0;
			low_lane_select_n <= 1'b1;
			high_lane_select_n <= 1'b1;
			address_lines <= '0;
			data_pins_o <= '0;
		end else begin
			select_low_active_n <= !busy_d;
			select_high_active <= busy_d;
			write_strobe_n <= !in_write;
			output_gate_n <= !in_read;
			data_pins_oe <= in_write;
			if (start) begin
				address_lines <= req_addr;
				data_pins_o <= req_wdata;
				low_lane_select_n <= !req_lane_en[0];
				high_lane_select_n <= !req_lane_en[1];
			end else if (!busy_d) begin
				low_lane_select_n <= 1'b1;
				high_lane_select_n <= 1'b1;
			end
		end
	end

	// ************************************************************
	// response
	// ************************************************************
	// unselected lanes float on the pins, so mask them to zero
	logic [sram_port_pkg::LANE_W-1:0] lo_byte, hi_byte;
	assign lo_byte = low_lane_select_n ? '0
		: data_pins_i[sram_port_pkg::LANE_W-1:0];
	assign hi_byte = high_lane_select_n ? '0
		: data_pins_i[sram_port_pkg::DATA_W-1:sram_port_pkg::LANE_W];

	// ready, done pulse and captured read word
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			req_ready <= (state_d == sram_port_pkg::ST_IDLE);
			rsp_valid <= (state_q != sram_port_pkg::ST_IDLE) && (state_d == sram_port_pkg::ST_DONE);
			if ((state_q == sram_port_pkg::ST_READ) && cnt_end) begin
				rsp_rdata <= {hi_byte, lo_byte};
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	// bus ownership: host drives only while writing
	a_no_contention: assert property (@(posedge sys_clk) disable iff (srst)
		!(data_pins_oe && !output_gate_n))
		else $error("bus driven during read");
	a_oe_write: assert property (@(posedge sys_clk) disable iff (srst)
		data_pins_oe == !write_strobe_n)
		else $error("drive enable not matching write");
	a_gate_exclusive: assert property (@(posedge sys_clk) disable iff (srst)
		!(!write_strobe_n && !output_gate_n))
		else $error("gate and strobe both low");

	// write pulse length and its end
	a_write_width: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(write_strobe_n) |-> !write_strobe_n [*4])
		else $error("write pulse short");
	a_write_max: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(write_strobe_n) |-> ##4 write_strobe_n)
		else $error("write pulse not ended");
	a_strobe_end: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(write_strobe_n) |-> $rose(select_low_active_n))
		else $error("select outlived write strobe");
	a_select_write: assert property (@(posedge sys_clk) disable iff (srst)
		!write_strobe_n |-> !select_low_active_n && select_high_active)
		else $error("write without select");

	// write data and address held for the whole access
	a_data_stable: assert property (@(posedge sys_clk) disable iff (srst)
		!write_strobe_n && !$past(write_strobe_n) |-> $stable(data_pins_o) && data_pins_oe)
		else $error("write data moved");
	a_addr_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!select_low_active_n && !$past(select_low_active_n) |-> $stable(address_lines))
		else $error("address moved");
	a_lanes_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!select_low_active_n && !$past(select_low_active_n)
		|-> $stable({low_lane_select_n, high_lane_select_n}))
		else $error("lane selects moved");

	// read gate length, its release and select
	a_read_wait: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(output_gate_n) |-> !output_gate_n [*5])
		else $error("read too short");
	a_read_end: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(output_gate_n) |-> ##6 output_gate_n)
		else $error("read gate not released");
	a_gate_select: assert property (@(posedge sys_clk) disable iff (srst)
		!output_gate_n |-> !select_low_active_n && select_high_active)
		else $error("read gate without select");

	// selects move as a pair and idle state is quiet
	a_select_pair: assert property (@(posedge sys_clk) disable iff (srst)
		select_low_active_n == !select_high_active)
		else $error("select lines disagree");
	a_lanes_idle: assert property (@(posedge sys_clk) disable iff (srst)
		select_low_active_n |-> low_lane_select_n && high_lane_select_n)
		else $error("lanes active while idle");
	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		select_low_active_n |-> !data_pins_oe && write_strobe_n && output_gate_n)
		else $error("pins active while deselected");

	// user handshake
	a_ready_idle: assert property (@(posedge sys_clk) disable iff (srst)
		!select_low_active_n |-> !req_ready)
		else $error("ready during access");
	a_rsp_pulse: assert property (@(posedge sys_clk) disable iff (srst)
		rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
endmodule : sram_host

// ---- design/sram_port_pkg.sv ----
package sram_port_pkg;
	// ************************************************************
	// geometry
	// ************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	// ************************************************************
	// timing in ns, fastest grade by default
	// ************************************************************
	localparam int CLK_NS = 10;
	localparam int WRITE_PULSE_NS = 35;
	localparam int SELECT_TO_END_NS = 35;
	localparam int ACCESS_NS = 45;
	// least times round up
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SELECT_TO_END_CYC = (SELECT_TO_END_NS + CLK_NS - 1) / CLK_NS;
	// one extra cycle covers the input sampling register
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int CNT_W = 4;
	// ************************************************************
	// states
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b11,
		ST_DONE = 2'b10
	} state_t;
endpackage : sram_port_pkg

// ---- test/sram_dev.sv ----
// ************
// memory device model
// ************
module sram_dev (
	// clock and pins from the host
	input wire logic sys_clk,
	input wire logic [17:0] address_lines,
	input wire logic select_low_active_n,
	input wire logic select_high_active,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic low_lane_select_n,
	input wire logic high_lane_select_n,
	input wire logic [15:0] data_pins_o,
	input wire logic data_pins_oe,
	// pins to the host and misuse flag
	output logic [15:0] data_pins_i,
	output logic bad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [17:0]];
	logic [15:0] q, wd;
	logic [17:0] wa;
	logic [1:0] wl;
	logic sel, act, rd, ok, tog = 0;
	realtime t_acc, t_wr;
	initial bad = 0;
	assign sel = !select_low_active_n && select_high_active;
	assign act = sel && !write_strobe_n;
	assign rd = sel && write_strobe_n && !output_gate_n;
	// start of access and of write
	always @(address_lines, rd, low_lane_select_n, high_lane_select_n) t_acc = $realtime;
	always @(posedge act) t_wr = $realtime;
	// capture write values and bus misuse before each edge
	always @(posedge sys_clk) begin
		if (act && !data_pins_oe) bad = 1;
		if (rd && data_pins_oe) bad = 1;
		{wa, wd, wl} = {address_lines, data_pins_o, high_lane_select_n, low_lane_select_n};
	end
	// store selected lanes at the end of a write
	always @(negedge act) begin
		if ($realtime - t_wr < 35.0) bad = 1;
		if (!mem.exists(wa)) mem[wa] = 16'h0000;
		if (!wl[0]) mem[wa][7:0] = wd[7:0];
		if (!wl[1]) mem[wa][15:8] = wd[15:8];
	end
	// read lanes once access time passed, else a toggling pattern
	always @(negedge sys_clk) begin
		q = mem.exists(address_lines) ? mem[address_lines] : 16'h0000;
		ok = rd && ($realtime - t_acc >= 45.0);
		data_pins_i[7:0] = (ok && !low_lane_select_n) ? q[7:0] : {8{tog}};
		data_pins_i[15:8] = (ok && !high_lane_select_n) ? q[15:8] : {8{tog}};
		tog = ~tog;
	end
endmodule : sram_dev

// ---- test/async_sram_16bit_port_tb.sv ----
module async_sram_16bit_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [17:0] a; logic [15:0] d; logic [1:0] l;} row_t;
	logic sys_clk = 0, srst = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid, bad;
	logic select_low_active_n, select_high_active, write_strobe_n, output_gate_n;
	logic low_lane_select_n, high_lane_select_n, data_pins_oe;
	logic [17:0] req_addr = 0, address_lines;
	logic [15:0] req_wdata = 0, rsp_rdata, data_pins_i, data_pins_o;
	logic [1:0] req_lane_en = 0;
	int err_total = 0, compares = 0;
	// writes, then reads expecting merged lanes and no aliasing
	row_t rows [11] = '{{1'b1, 18'h00000, 16'h1234, 2'h3}, {1'b0, 18'h00000, 16'h1234, 2'h3},
		{1'b1, 18'h00000, 16'habcd, 2'h1}, {1'b0, 18'h00000, 16'h12cd, 2'h3},
		{1'b1, 18'h3ffff, 16'h5a5a, 2'h2}, {1'b0, 18'h3ffff, 16'h5a00, 2'h3},
		{1'b0, 18'h3ffff, 16'h5a00, 2'h2}, {1'b1, 18'h20000, 16'hffff, 2'h3},
		{1'b1, 18'h00000, 16'h0000, 2'h0}, {1'b0, 18'h00000, 16'h00cd, 2'h1},
		{1'b0, 18'h20000, 16'hffff, 2'h3}};
	always #5 sys_clk = ~sys_clk;
	sram_host uut (.sys_clk, .srst, .req_valid, .req_write, .req_addr, .req_wdata,
		.req_lane_en, .req_ready, .rsp_valid, .rsp_rdata, .address_lines,
		.select_low_active_n, .select_high_active, .write_strobe_n, .output_gate_n,
		.low_lane_select_n, .high_lane_select_n, .data_pins_i, .data_pins_o, .data_pins_oe);
	sram_dev dev (.sys_clk, .address_lines, .select_low_active_n, .select_high_active,
		.write_strobe_n, .output_gate_n, .low_lane_select_n, .high_lane_select_n,
		.data_pins_o, .data_pins_oe, .data_pins_i, .bad);
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// one request, held until taken, then wait for its answer
	task automatic acc(row_t r);
		int n;
		@(negedge sys_clk);
		{req_valid, req_write, req_addr, req_wdata, req_lane_en} = {1'b1, r};
		for (n = 0; req_ready !== 1'b1 && n < 40; n++) @(negedge sys_clk);
		@(negedge sys_clk);
		req_valid = 0;
		for (n = 0; rsp_valid !== 1'b1 && n < 40; n++) @(negedge sys_clk);
		chk("rsp_valid", 16'h1, {15'h0, rsp_valid});
		if (!r.w) chk("rdata", r.d, rsp_rdata);
	endtask : acc
	// main sequence
	initial begin
		repeat (8) @(negedge sys_clk);
		chk("sel_n", 16'h1, {15'h0, select_low_active_n});
		chk("oe", 16'h0, {15'h0, data_pins_oe});
		srst = 0;
		foreach (rows[i]) acc(rows[i]);
		// reset in the middle of a read drops every pin at once
		@(negedge sys_clk);
		{req_valid, req_write, req_addr, req_lane_en} = {1'b1, 1'b0, 18'h00000, 2'h3};
		repeat (3) @(negedge sys_clk);
		req_valid = 0;
		srst = 1;
		@(negedge sys_clk);
		chk("sel_n_rst", 16'h1, {15'h0, select_low_active_n});
		chk("gate_n_rst", 16'h1, {15'h0, output_gate_n});
		chk("rsp_rst", 16'h0, {15'h0, rsp_valid});
		chk("ready_rst", 16'h0, {15'h0, req_ready});
		srst = 0;
		@(negedge sys_clk);
		chk("ready_after", 16'h1, {15'h0, req_ready});
		acc(rows[3]);
		chk("misuse", 16'h0, {15'h0, bad});
		test_done();
	end
	// watchdog
	initial begin
		#20000;
		err_total++;
		test_done();
	end
endmodule : async_sram_16bit_port_tb
